//--- hw/lsf_pkg.sv
// Purpose: Shared constants for the flash safety timer and backlight fade block
// Assumes: 100 MHz internal clock, register access strobes from the serial interface
// Notes: Offsets, cycle counts and most bit positions live here; the top codes the safety enable bits and several reset values itself
package lsf_pkg;
  localparam logic [7:0] ADDR_COLOUR_PEAK = 8'h02;
  localparam logic [7:0] ADDR_BL_CTRL = 8'h03;
  localparam logic [7:0] ADDR_PRIMARY = 8'h04;
  localparam logic [7:0] ADDR_SECONDARY = 8'h05;
  localparam logic [7:0] ADDR_GPIO_CTRL = 8'h06;
  localparam logic [7:0] ADDR_SAFETY_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PIN_GATING = 8'h2b;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int BL_SLOPE_BIT = 5;
  localparam int BL_FADE_SEL_BIT = 4;
  localparam int BL_FADE_EN_BIT = 3;
  localparam int BL_COMBINED_BIT = 2;
  localparam int BL_PRIMARY_EN_BIT = 1;
  localparam int BL_SECONDARY_EN_BIT = 0;
  localparam int GATE_PRIMARY_BIT = 1;
  localparam int GATE_SECONDARY_BIT = 0;
  localparam int GPIO_PIN_EN_BIT = 4;
  localparam int SAFE_FLASH_BIT = 3;
  localparam int SAFE_TRIPPED_BIT = 7;
  localparam int CLOCK_MHZ = 100;
  localparam int SAFETY_TIME_MS = 1000;
  localparam int SAFETY_CYCLES = SAFETY_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int FADE_FULL_SCALE = 255;
  localparam int FADE_SLOW_MS = 1300;
  localparam int FADE_FAST_MS = 650;
  localparam int FADE_SLOW_CYCLES = FADE_SLOW_MS * 1000 * CLOCK_MHZ / FADE_FULL_SCALE;
  localparam int FADE_FAST_CYCLES = FADE_FAST_MS * 1000 * CLOCK_MHZ / FADE_FULL_SCALE;
  localparam int SAFE_CNT_W = 27;
  localparam int FADE_CNT_W = 20;
endpackage : lsf_pkg

//--- hw/lsf_ctl_if.sv
// Purpose: Carries safety and fade signals between the top and its helpers
// Assumes: Single clock domain
// Notes: Two-entry arrays index 0 primary string, 1 secondary string
`timescale 1ns/1ps
interface lsf_ctl_if;
  logic [2:0] safety_en;
  logic flash_mode;
  logic trigger;
  logic colour_access;
  logic tripped;
  logic [2:0] driver_off;
  logic [1:0][7:0] target;
  logic [1:0] apply;
  logic fast;
  logic [1:0][7:0] level;
  modport top
  (
    output safety_en, flash_mode, trigger, colour_access, target, apply, fast,
    input tripped, driver_off, level
  );
  modport safety
  (
    input safety_en, flash_mode, trigger, colour_access,
    output tripped, driver_off
  );
  modport fade
  (
    input target, apply, fast,
    output level
  );
endinterface : lsf_ctl_if

//--- hw/lsf_safety.sv
// Purpose: One-second flash safety timer
// Assumes: Trigger already qualified by the pin enable
// Notes: Tripped state clears only when every enable is cleared
`timescale 1ns/1ps
module lsf_safety #(
  parameter int SAFETY_CYC = lsf_pkg::SAFETY_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  lsf_ctl_if.safety ctl
);
  import lsf_pkg::*;
  localparam logic [SAFE_CNT_W-1:0] LAST = SAFE_CNT_W'(SAFETY_CYC - 1);
  logic [SAFE_CNT_W-1:0] cnt_r, cnt_nxt;
  logic trip_r, trip_nxt, armed_r, armed_nxt, trig_q_r, trig_q_nxt;
  logic any_en, rise;

  always_comb
  begin
    any_en = |ctl.safety_en;
    rise = ctl.trigger && !trig_q_r && armed_r;
    cnt_nxt = cnt_r;
    trip_nxt = trip_r;
    trig_q_nxt = ctl.trigger;
    armed_nxt = armed_r;
    if (!ctl.flash_mode)
      armed_nxt = 1'b1;
    else if (trig_q_r && !ctl.trigger)
      armed_nxt = 1'b0;
    if (!any_en)
    begin
      cnt_nxt = '0;
      trip_nxt = 1'b0;
    end
    else if (!trip_r)
    begin
      if (!ctl.flash_mode)
      begin
        if (ctl.colour_access)
          cnt_nxt = '0;
        else if (cnt_r == LAST)
          trip_nxt = 1'b1;
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      else if (rise)
        cnt_nxt = SAFE_CNT_W'(1);
      else if (ctl.trigger && trig_q_r && armed_r)
      begin
        if (cnt_r == LAST)
          trip_nxt = 1'b1;
        else
          cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      trip_r <= 1'b0;
      armed_r <= 1'b0;
      trig_q_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      trip_r <= trip_nxt;
      armed_r <= armed_nxt;
      trig_q_r <= trig_q_nxt;
    end
  end

  assign ctl.tripped = trip_r;
  assign ctl.driver_off = trip_r ? ctl.safety_en : 3'h0;

  trip_at_limit_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(trip_r) |-> $past(cnt_r) == LAST)
    else $error("trip without full count");
  access_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!ctl.flash_mode && ctl.colour_access && !trip_r && any_en) |=> cnt_r == '0)
    else $error("access did not clear counter");
  trip_holds_a: assert property (@(posedge clock) disable iff (!rst_n)
    (trip_r && any_en) |=> trip_r)
    else $error("trip cleared while enabled");
  all_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    !any_en |=> (!trip_r && cnt_r == '0))
    else $error("counter not cleared");
  trigger_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ctl.flash_mode && !ctl.trigger && any_en) |=> $stable(cnt_r))
    else $error("counted with trigger low");
endmodule : lsf_safety

//--- hw/lsf_fade.sv
// Purpose: Automatic fade stepping for two strings
// Assumes: Target and apply flags come from the control registers
// Notes: A string not under fade follows its target at once
`timescale 1ns/1ps
module lsf_fade #(
  parameter int SLOW_CYC = lsf_pkg::FADE_SLOW_CYCLES,
  parameter int FAST_CYC = lsf_pkg::FADE_FAST_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  lsf_ctl_if.fade ctl
);
  import lsf_pkg::*;
  logic [FADE_CNT_W-1:0] tick_r, tick_nxt, limit;
  logic tick;
  logic [1:0][7:0] level_r, level_nxt;

  always_comb
  begin
    limit = ctl.fast ? FADE_CNT_W'(FAST_CYC - 1) : FADE_CNT_W'(SLOW_CYC - 1);
    tick = (tick_r >= limit);
    tick_nxt = tick ? '0 : tick_r + 1'b1;
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_str
    always_comb
    begin
      level_nxt[i] = level_r[i];
      if (!ctl.apply[i])
        level_nxt[i] = ctl.target[i];
      else if (tick && level_r[i] < ctl.target[i])
        level_nxt[i] = level_r[i] + 8'h01;
      else if (tick && level_r[i] > ctl.target[i])
        level_nxt[i] = level_r[i] - 8'h01;
    end

    one_step_a: assert property (@(posedge clock) disable iff (!rst_n)
      ctl.apply[i] && $past(ctl.apply[i]) |-> (level_r[i] - $past(level_r[i]) == 8'h00
        || level_r[i] - $past(level_r[i]) == 8'h01 || $past(level_r[i]) - level_r[i] == 8'h01))
      else $error("fade moved more than one code");
    direct_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
      !ctl.apply[i] |=> level_r[i] == $past(ctl.target[i]))
      else $error("unfaded string did not follow target");
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_r <= '0;
      level_r <= '0;
    end
    else
    begin
      tick_r <= tick_nxt;
      level_r <= level_nxt;
    end
  end

  assign ctl.level = level_r;
endmodule : lsf_fade

//--- hw/lsf_top.sv
// Purpose: Register file, pin gating and driver outputs of the lighting block
// Assumes: reg_access pulses once per completed serial read or write
// Notes: Read data is registered on the access pulse
`timescale 1ns/1ps
module lsf_top #(
  parameter int SAFETY_CYC = lsf_pkg::SAFETY_CYCLES,
  parameter int SLOW_CYC = lsf_pkg::FADE_SLOW_CYCLES,
  parameter int FAST_CYC = lsf_pkg::FADE_FAST_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_access,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic flash_pwm_pin,
  input wire logic [2:0] colour_drive_req,
  output logic red_sink_output,
  output logic green_sink_output,
  output logic blue_sink_output,
  output logic [7:0] colour_peak_level,
  output logic [7:0] primary_level,
  output logic [7:0] secondary_level
);
  import lsf_pkg::*;
  lsf_ctl_if ctl ();
  logic [7:0] colour_peak_r, colour_peak_nxt, bl_ctrl_r, bl_ctrl_nxt;
  logic [7:0] primary_r, primary_nxt, secondary_r, secondary_nxt;
  logic [7:0] gpio_ctrl_r, gpio_ctrl_nxt, gating_r, gating_nxt;
  logic [3:0] safe_ctrl_r, safe_ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] colour_r, colour_nxt;
  logic [7:0] prim_out_r, prim_out_nxt, sec_out_r, sec_out_nxt;
  logic wr, pin_en, prim_on, sec_on, combined;

  lsf_safety #(.SAFETY_CYC(SAFETY_CYC)) u_safety
  (
    .clock(clock),
    .rst_n(rst_n),
    .ctl(ctl.safety)
  );

  lsf_fade #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_fade
  (
    .clock(clock),
    .rst_n(rst_n),
    .ctl(ctl.fade)
  );

  always_comb
  begin
    wr = reg_access && reg_write;
    colour_peak_nxt = (wr && reg_addr == ADDR_COLOUR_PEAK) ? reg_wdata : colour_peak_r;
    bl_ctrl_nxt = (wr && reg_addr == ADDR_BL_CTRL) ? reg_wdata : bl_ctrl_r;
    primary_nxt = (wr && reg_addr == ADDR_PRIMARY) ? reg_wdata : primary_r;
    secondary_nxt = (wr && reg_addr == ADDR_SECONDARY) ? reg_wdata : secondary_r;
    gpio_ctrl_nxt = (wr && reg_addr == ADDR_GPIO_CTRL) ? reg_wdata : gpio_ctrl_r;
    gating_nxt = (wr && reg_addr == ADDR_PIN_GATING) ? reg_wdata : gating_r;
    safe_ctrl_nxt = (wr && reg_addr == ADDR_SAFETY_CTRL) ? reg_wdata[3:0] : safe_ctrl_r;
    rdata_nxt = rdata_r;
    if (reg_access && !reg_write)
    begin
      case (reg_addr)
        ADDR_COLOUR_PEAK: rdata_nxt = colour_peak_r;
        ADDR_BL_CTRL: rdata_nxt = bl_ctrl_r;
        ADDR_PRIMARY: rdata_nxt = primary_r;
        ADDR_SECONDARY: rdata_nxt = secondary_r;
        ADDR_GPIO_CTRL: rdata_nxt = gpio_ctrl_r;
        ADDR_PIN_GATING: rdata_nxt = gating_r;
        ADDR_SAFETY_CTRL: rdata_nxt = {ctl.tripped, 3'h0, safe_ctrl_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    pin_en = gpio_ctrl_r[GPIO_PIN_EN_BIT];
    combined = bl_ctrl_r[BL_COMBINED_BIT];
    ctl.safety_en = safe_ctrl_r[2:0];
    ctl.flash_mode = safe_ctrl_r[SAFE_FLASH_BIT];
    ctl.trigger = pin_en && flash_pwm_pin;
    ctl.colour_access = reg_access && reg_addr == ADDR_COLOUR_PEAK;
    ctl.target[0] = primary_r;
    ctl.target[1] = combined ? primary_r : secondary_r;
    ctl.apply[0] = bl_ctrl_r[BL_FADE_EN_BIT] && !bl_ctrl_r[BL_FADE_SEL_BIT];
    ctl.apply[1] = bl_ctrl_r[BL_FADE_EN_BIT]
      && (bl_ctrl_r[BL_FADE_SEL_BIT] || combined);
    ctl.fast = bl_ctrl_r[BL_SLOPE_BIT];
    prim_on = bl_ctrl_r[BL_PRIMARY_EN_BIT]
      && (!(pin_en && gating_r[GATE_PRIMARY_BIT]) || flash_pwm_pin);
    sec_on = bl_ctrl_r[BL_SECONDARY_EN_BIT]
      && (!(pin_en && gating_r[GATE_SECONDARY_BIT]) || flash_pwm_pin);
    prim_out_nxt = prim_on ? ctl.level[0] : 8'h00;
    sec_out_nxt = sec_on ? ctl.level[1] : 8'h00;
    colour_nxt = colour_drive_req & ~ctl.driver_off;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      colour_peak_r <= REG_RESET;
      bl_ctrl_r <= REG_RESET;
      primary_r <= REG_RESET;
      secondary_r <= REG_RESET;
      gpio_ctrl_r <= REG_RESET;
      gating_r <= REG_RESET;
      safe_ctrl_r <= 4'h0;
      rdata_r <= REG_RESET;
      colour_r <= 3'h0;
      prim_out_r <= 8'h00;
      sec_out_r <= 8'h00;
    end
    else
    begin
      colour_peak_r <= colour_peak_nxt;
      bl_ctrl_r <= bl_ctrl_nxt;
      primary_r <= primary_nxt;
      secondary_r <= secondary_nxt;
      gpio_ctrl_r <= gpio_ctrl_nxt;
      gating_r <= gating_nxt;
      safe_ctrl_r <= safe_ctrl_nxt;
      rdata_r <= rdata_nxt;
      colour_r <= colour_nxt;
      prim_out_r <= prim_out_nxt;
      sec_out_r <= sec_out_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign red_sink_output = colour_r[0];
  assign green_sink_output = colour_r[1];
  assign blue_sink_output = colour_r[2];
  assign colour_peak_level = colour_peak_r;
  assign primary_level = prim_out_r;
  assign secondary_level = sec_out_r;

  tripped_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ctl.tripped && safe_ctrl_r[0]) |=> !colour_r[0])
    else $error("tripped red driver still on");
  gated_dark_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pin_en && gating_r[GATE_PRIMARY_BIT] && !flash_pwm_pin) |=> prim_out_r == 8'h00)
    else $error("gated primary string lit with pin low");
endmodule : lsf_top

//--- tb/lsf_host_model.sv
// Purpose: Host side of the register bus, one byte per access
// Assumes: Access taken on the edge where reg_access is high
// Notes: Address and data lines scrambled while idle
`timescale 1ns/1ps
module lsf_host_model
(
  input wire logic clock,
  output logic reg_access,
  output logic reg_write,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_access = 1'b0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_access <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_access <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : lsf_host_model

//--- tb/test_led_safety_timer_and_fade.sv
// Purpose: Self-checking bench for the safety timer and backlight fade
// Assumes: Shortened safety and fade counts
// Notes: Host model drives the register bus
`timescale 1ns/1ps
module test_led_safety_timer_and_fade;
  import lsf_pkg::*;
  localparam int SC = 20;
  logic clock, rst_n, flash_pwm_pin;
  logic reg_access, reg_write;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] colour_peak_level, primary_level, secondary_level;
  logic [2:0] colour_drive_req;
  logic red_sink_output, green_sink_output, blue_sink_output;
  int mismatches = 0;
  int tests_run = 0;

  lsf_top #(.SAFETY_CYC(SC), .SLOW_CYC(8), .FAST_CYC(4)) dut_u
  (
    .clock, .rst_n, .reg_access, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
    .flash_pwm_pin, .colour_drive_req, .red_sink_output, .green_sink_output,
    .blue_sink_output, .colour_peak_level, .primary_level, .secondary_level
  );
  lsf_host_model host_u
  (
    .clock, .reg_access, .reg_write, .reg_addr, .reg_wdata, .reg_rdata
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic pin(input logic v);
    @(posedge clock);
    flash_pwm_pin <= v;
    #1;
  endtask : pin

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    check(d, e);
  endtask : rc

  task automatic fade_time(input logic [7:0] goal, input int lo, input int hi);
    int n;
    n = 0;
    while (primary_level !== goal && n < 200)
    begin
      cyc(1);
      n++;
    end
    check(8'(n >= lo && n <= hi), 8'h01);
  endtask : fade_time

  task automatic t_regs();
    rc(ADDR_BL_CTRL, 8'h00);
    rc(ADDR_PRIMARY, 8'h00);
    rc(ADDR_PIN_GATING, 8'h00);
    host_u.wr(8'h10, 8'hff);
    rc(8'h10, 8'h00);
    host_u.wr(ADDR_COLOUR_PEAK, 8'ha5);
    cyc(2);
    check(colour_peak_level, 8'ha5);
    @(posedge clock);
    colour_drive_req <= 3'b101;
    cyc(2);
    check(8'(red_sink_output), 8'h01);
    check(8'(green_sink_output), 8'h00);
    check(8'(blue_sink_output), 8'h01);
    @(posedge clock);
    colour_drive_req <= 3'b111;
    cyc(2);
    check(8'(green_sink_output), 8'h01);
  endtask : t_regs

  task automatic t_watch();
    host_u.wr(ADDR_SAFETY_CTRL, 8'h05);
    repeat (3)
    begin
      cyc(12);
      rc(ADDR_COLOUR_PEAK, 8'ha5);
      check(8'(red_sink_output), 8'h01);
    end
    host_u.wr(ADDR_COLOUR_PEAK, 8'ha5);
    cyc(18);
    check(8'(red_sink_output), 8'h01);
    cyc(SC + 10);
    check(8'(red_sink_output), 8'h00);
    check(8'(blue_sink_output), 8'h00);
    check(8'(green_sink_output), 8'h01);
    rc(ADDR_SAFETY_CTRL, 8'h85);
    rc(ADDR_COLOUR_PEAK, 8'ha5);
    host_u.wr(ADDR_SAFETY_CTRL, 8'h04);
    cyc(3);
    check(8'(red_sink_output), 8'h01);
    check(8'(blue_sink_output), 8'h00);
    host_u.wr(ADDR_SAFETY_CTRL, 8'h00);
    cyc(3);
    check(8'(blue_sink_output), 8'h01);
    rc(ADDR_SAFETY_CTRL, 8'h00);
  endtask : t_watch

  task automatic t_trigger();
    host_u.wr(ADDR_GPIO_CTRL, 8'h10);
    host_u.wr(ADDR_SAFETY_CTRL, 8'h0a);
    pin(1'b1);
    cyc(SC / 2);
    check(8'(green_sink_output), 8'h01);
    pin(1'b0);
    cyc(2);
    pin(1'b1);
    cyc(SC + 10);
    check(8'(green_sink_output), 8'h01);
    pin(1'b0);
    host_u.wr(ADDR_SAFETY_CTRL, 8'h02);
    host_u.wr(ADDR_SAFETY_CTRL, 8'h0a);
    pin(1'b1);
    cyc(SC + 10);
    check(8'(green_sink_output), 8'h00);
    check(8'(red_sink_output), 8'h01);
    pin(1'b0);
    rc(ADDR_SAFETY_CTRL, 8'h8a);
    host_u.wr(ADDR_SAFETY_CTRL, 8'h00);
    cyc(3);
    check(8'(green_sink_output), 8'h01);
  endtask : t_trigger

  task automatic t_gate();
    host_u.wr(ADDR_BL_CTRL, 8'h03);
    host_u.wr(ADDR_PRIMARY, 8'h10);
    host_u.wr(ADDR_SECONDARY, 8'h20);
    host_u.wr(ADDR_PIN_GATING, 8'h02);
    cyc(3);
    check(primary_level, 8'h00);
    check(secondary_level, 8'h20);
    pin(1'b1);
    cyc(3);
    check(primary_level, 8'h10);
    host_u.wr(ADDR_PIN_GATING, 8'h01);
    pin(1'b0);
    cyc(3);
    check(primary_level, 8'h10);
    check(secondary_level, 8'h00);
    host_u.wr(ADDR_PIN_GATING, 8'h00);
  endtask : t_gate

  task automatic t_fade();
    logic [7:0] seq [4] = '{8'h20, 8'h20, 8'h28, 8'h2a};
    foreach (seq[i])
      host_u.wr(ADDR_BL_CTRL, seq[i]);
    host_u.wr(ADDR_PRIMARY, 8'h13);
    fade_time(8'h13, 9, 16);
    host_u.wr(ADDR_BL_CTRL, 8'h0a);
    host_u.wr(ADDR_PRIMARY, 8'h10);
    fade_time(8'h10, 17, 28);
    host_u.wr(ADDR_BL_CTRL, 8'h07);
    cyc(3);
    check(secondary_level, 8'h10);
    host_u.wr(ADDR_BL_CTRL, 8'h0f);
    host_u.wr(ADDR_PRIMARY, 8'h14);
    cyc(3);
    check(8'(secondary_level <= 8'h11), 8'h01);
    cyc(60);
    check(secondary_level, 8'h14);
    host_u.wr(ADDR_BL_CTRL, 8'h1b);
    host_u.wr(ADDR_SECONDARY, 8'h18);
    host_u.wr(ADDR_PRIMARY, 8'h00);
    cyc(3);
    check(primary_level, 8'h00);
    check(8'(secondary_level !== 8'h18), 8'h01);
  endtask : t_fade

  task automatic t_reset();
    host_u.wr(ADDR_SAFETY_CTRL, 8'h01);
    cyc(10);
    check(8'(red_sink_output), 8'h01);
    @(posedge clock);
    rst_n <= 1'b0;
    cyc(2);
    check(8'(red_sink_output), 8'h00);
    check(secondary_level, 8'h00);
    @(posedge clock);
    rst_n <= 1'b1;
    cyc(1);
    rc(ADDR_SAFETY_CTRL, 8'h00);
    rc(ADDR_BL_CTRL, 8'h00);
    check(8'(red_sink_output), 8'h01);
  endtask : t_reset

  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    flash_pwm_pin = 1'b0;
    colour_drive_req = 3'b111;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_watch();
    t_trigger();
    t_gate();
    t_fade();
    t_reset();
    tally_and_finish();
  end
endmodule : test_led_safety_timer_and_fade
